// >>> rtl/arsc_pkg.sv
// Register map, field layout and encodings for the reference select control
package arsc_pkg;
    // Special-function register addresses
    localparam logic [7:0] REF_CTRL_ADDR    = 8'hD1;
    localparam logic [7:0] FACTORY_TEMP_OFFSET_LOW_ADDR    = 8'h85;
    localparam logic [7:0] FACTORY_TEMP_OFFSET_HIGH_ADDR   = 8'h86;
    // Control register field positions
    localparam int         FLD_GND_SEL      = 5;
    localparam int         FLD_REFSEL_HI    = 4;
    localparam int         FLD_REFSEL_LO    = 3;
    localparam int         FLD_TEMP_EN      = 2;
    localparam int         FLD_PREC_EN      = 0;
    // Control register values after reset
    localparam logic       GND_SEL_RESET    = 1'b0;
    localparam logic [1:0] REFSEL_RESET     = 2'h3;
    localparam logic       TEMP_EN_RESET    = 1'b0;
    localparam logic       PREC_EN_RESET    = 1'b0;
    // Low-byte position of the two least offset bits
    localparam int         FACTORY_TEMP_OFFSET_LOW_POS     = 6;
    // Converter channel code of the temperature sensor
    localparam logic [4:0] CHAN_TEMP_SENSOR = 5'h1B;
    // Voltage reference routing
    typedef enum logic [1:0] {
        ARSC_REF_EXT_PIN,
        ARSC_REF_MAIN_SUPPLY,
        ARSC_REF_DIG_SUPPLY,
        ARSC_REF_HIGH_SPEED
    } arsc_refsel_e;
endpackage

// >>> rtl/arsc_sync.sv
// Three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/1ps
module arsc_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change counts only once the two later stages agree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_out <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            sync_out <= s3_reg;
        end
    end
endmodule

// >>> rtl/arsc_offset_rom.sv
// Read-only factory temperature offset byte views
`timescale 1ns/1ps
module arsc_offset_rom #(
    parameter logic [9:0] OFFSET_VALUE = 10'h200
) (
    // Register views
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);
    always_comb begin
        high_byte = OFFSET_VALUE[9:2];
        low_byte  = 8'h00;
        low_byte[arsc_pkg::FACTORY_TEMP_OFFSET_LOW_POS +: 2] = OFFSET_VALUE[1:0];
    end
endmodule

// >>> rtl/arsc_ref_ctrl.sv
// Reference and ground selection control with sensor enable and offset registers
// What this block does
// - Per-part 10-bit factory temperature offset, readable, never writable
// - Offset high byte returns offset bits 9 to 2, read-only
// - Offset low byte returns offset bits 1 and 0 in bits 7 and 6
// - Offset low byte bits 5 to 0 read zero, writes ignored
// - Ground select 1 uses analog ground pin, 0 uses ground pin
// - Select code 11 routes the high-speed reference to the converter
// - High-speed reference powered only on converter demand, low power otherwise
// - Precision enable with select 00 powers precision reference and drives pin
// - Select 01 chooses main supply, 10 chooses regulated digital supply
// - Sampling the temperature sensor forces internal chip ground
// - High-speed reference selected forces internal ground during conversion
// - Sensor enable cleared puts sensor output in high impedance
// - Control bits: ground 5, select 4:3, sensor 2, precision 0
// - Writing sensor enable bit sets or clears the temperature sensor
`timescale 1ns/1ps
module arsc_ref_ctrl #(
    parameter logic [9:0] FACTORY_TEMP_OFFSET = 10'h200
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    // Converter status
    input  wire logic       conv_tracking,
    input  wire logic       conv_converting,
    input  wire logic [4:0] conv_channel,
    // Analog controls
    output logic [1:0]      vref_mux_sel,
    output logic            hs_ref_enable,
    output logic            prec_ref_enable,
    output logic            vref_pin_drive,
    output logic            gnd_use_analog_ground_pin_pin,
    output logic            gnd_use_internal,
    output logic            temp_sensor_enable,
    output logic            temp_sensor_hiz
);
    logic       analog_ground_select_reg;
    logic [1:0] reference_select_reg;
    logic       temp_sensor_enable_reg;
    logic       precision_ref_enable_reg;
    logic       tracking_s;
    logic       converting_s;
    logic [7:0] factory_temp_offset_high;
    logic [7:0] factory_temp_offset_low;
    logic [7:0] reference_control_reg;
    logic       hs_sel;
    logic       force_int_gnd;

    // Field layout must fit the byte-wide control and offset views
    if (arsc_pkg::FLD_GND_SEL > 7 || arsc_pkg::FLD_REFSEL_HI > 7
        || arsc_pkg::FLD_REFSEL_HI != arsc_pkg::FLD_REFSEL_LO + 1
        || arsc_pkg::FACTORY_TEMP_OFFSET_LOW_POS > 6) begin
        $error("field layout does not fit an eight-bit register");
    end

    // Converter status is sampled asynchronously to this clock
    arsc_sync u_sync_track (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in (conv_tracking),
        .sync_out (tracking_s)
    );

    arsc_sync u_sync_conv (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in (conv_converting),
        .sync_out (converting_s)
    );

    arsc_offset_rom #(
        .OFFSET_VALUE (FACTORY_TEMP_OFFSET)
    ) u_offset (
        .high_byte (factory_temp_offset_high),
        .low_byte  (factory_temp_offset_low)
    );

    // Control register write
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_ground_select_reg <= arsc_pkg::GND_SEL_RESET;
            reference_select_reg     <= arsc_pkg::REFSEL_RESET;
            temp_sensor_enable_reg   <= arsc_pkg::TEMP_EN_RESET;
            precision_ref_enable_reg <= arsc_pkg::PREC_EN_RESET;
        end else if (sfr_wr && sfr_addr == arsc_pkg::REF_CTRL_ADDR) begin
            analog_ground_select_reg <= sfr_wdata[arsc_pkg::FLD_GND_SEL];
            reference_select_reg     <= sfr_wdata[arsc_pkg::FLD_REFSEL_HI:
                                                  arsc_pkg::FLD_REFSEL_LO];
            temp_sensor_enable_reg   <= sfr_wdata[arsc_pkg::FLD_TEMP_EN];
            precision_ref_enable_reg <= sfr_wdata[arsc_pkg::FLD_PREC_EN];
        end
    end

    always_comb begin
        reference_control_reg = 8'h00;
        reference_control_reg[arsc_pkg::FLD_GND_SEL] = analog_ground_select_reg;
        reference_control_reg[arsc_pkg::FLD_REFSEL_HI:arsc_pkg::FLD_REFSEL_LO] =
            reference_select_reg;
        reference_control_reg[arsc_pkg::FLD_TEMP_EN] = temp_sensor_enable_reg;
        reference_control_reg[arsc_pkg::FLD_PREC_EN] = precision_ref_enable_reg;
    end

    // Registered read data, unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                arsc_pkg::REF_CTRL_ADDR:  sfr_rdata <= reference_control_reg;
                arsc_pkg::FACTORY_TEMP_OFFSET_HIGH_ADDR: sfr_rdata <= factory_temp_offset_high;
                arsc_pkg::FACTORY_TEMP_OFFSET_LOW_ADDR:  sfr_rdata <= factory_temp_offset_low;
                default:                  sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Sensor override covers sampling only, high-speed override conversion only
    assign hs_sel        = reference_select_reg == 2'(arsc_pkg::ARSC_REF_HIGH_SPEED);
    assign force_int_gnd = (tracking_s && conv_channel == arsc_pkg::CHAN_TEMP_SENSOR)
                         || (hs_sel && converting_s);

    // Reference routing and power
    // High-speed reference idles in low power outside a converter pass
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vref_mux_sel    <= arsc_pkg::REFSEL_RESET;
            hs_ref_enable   <= 1'b0;
            prec_ref_enable <= 1'b0;
            vref_pin_drive  <= 1'b0;
        end else begin
            vref_mux_sel    <= reference_select_reg;
            hs_ref_enable   <= hs_sel && (tracking_s || converting_s);
            prec_ref_enable <= precision_ref_enable_reg && reference_select_reg ==
                               2'(arsc_pkg::ARSC_REF_EXT_PIN);
            vref_pin_drive  <= precision_ref_enable_reg && reference_select_reg ==
                               2'(arsc_pkg::ARSC_REF_EXT_PIN);
        end
    end

    // Ground routing and sensor control
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gnd_use_analog_ground_pin_pin   <= 1'b0;
            gnd_use_internal   <= 1'b0;
            temp_sensor_enable <= 1'b0;
            temp_sensor_hiz    <= 1'b1;
        end else begin
            gnd_use_internal   <= force_int_gnd;
            gnd_use_analog_ground_pin_pin   <= analog_ground_select_reg && !force_int_gnd;
            temp_sensor_enable <= temp_sensor_enable_reg;
            temp_sensor_hiz    <= !temp_sensor_enable_reg;
        end
    end

    // Assertions
    // Multi-step converter behaviours as seen through the synchronisers
    sequence seq_temp_sample;
        tracking_s && conv_channel == arsc_pkg::CHAN_TEMP_SENSOR;
    endsequence

    sequence seq_hs_track;
        hs_sel && tracking_s;
    endsequence

    sequence seq_hs_handoff;
        seq_hs_track ##1 hs_sel && converting_s;
    endsequence

    sequence seq_pass_done;
        (tracking_s || converting_s) ##1 !tracking_s && !converting_s;
    endsequence

    AST_HS_ENABLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hs_ref_enable |-> $past(hs_sel) && $past(tracking_s || converting_s))
        else $error("high-speed reference on without demand");

    AST_HS_ON: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hs_sel && converting_s |=> hs_ref_enable)
        else $error("high-speed reference off during conversion");

    AST_HS_TRACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
        seq_hs_track |=> hs_ref_enable)
        else $error("high-speed reference off while tracking");

    AST_HS_OFF_SEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !hs_sel |=> !hs_ref_enable)
        else $error("high-speed reference on while not selected");

    AST_HS_HANDOFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        seq_hs_handoff |=> hs_ref_enable && gnd_use_internal && !gnd_use_analog_ground_pin_pin)
        else $error("tracking to conversion handoff wrong");

    AST_PASS_RELEASE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        seq_pass_done |=> !hs_ref_enable && !gnd_use_internal)
        else $error("reference or ground not released after pass");

    AST_INT_GND_TEMP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        seq_temp_sample |=> gnd_use_internal && !gnd_use_analog_ground_pin_pin)
        else $error("sensor sampling not on internal ground");

    AST_INT_GND_HS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hs_sel && converting_s |=> gnd_use_internal && !gnd_use_analog_ground_pin_pin)
        else $error("high-speed conversion not on internal ground");

    AST_GND_RELEASE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(tracking_s && conv_channel == arsc_pkg::CHAN_TEMP_SENSOR)
        && !(hs_sel && converting_s) |=> !gnd_use_internal)
        else $error("internal ground forced without cause");

    AST_ANALOG_GROUND_PIN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !force_int_gnd |=> gnd_use_analog_ground_pin_pin == $past(analog_ground_select_reg))
        else $error("ground pin choice wrong");

    AST_ANALOG_GROUND_PIN_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !analog_ground_select_reg |=> !gnd_use_analog_ground_pin_pin)
        else $error("analog ground pin used while not selected");

    AST_GND_EXCL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(gnd_use_internal && gnd_use_analog_ground_pin_pin))
        else $error("two ground references at once");

    AST_PREC: assert property (@(posedge sys_clk) disable iff (!arst_n)
        vref_pin_drive |-> $past(precision_ref_enable_reg)
        && $past(reference_select_reg) == 2'h0)
        else $error("precision reference driven wrongly");

    AST_PREC_ON: assert property (@(posedge sys_clk) disable iff (!arst_n)
        precision_ref_enable_reg && reference_select_reg == 2'(arsc_pkg::ARSC_REF_EXT_PIN)
        |=> prec_ref_enable && vref_pin_drive)
        else $error("precision reference not powered");

    AST_PREC_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !precision_ref_enable_reg || reference_select_reg != 2'(arsc_pkg::ARSC_REF_EXT_PIN)
        |=> !prec_ref_enable && !vref_pin_drive)
        else $error("precision reference on while not requested");

    AST_MUX_FOLLOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'h1 |=> vref_mux_sel == $past(reference_select_reg))
        else $error("reference mux select does not follow control");

    AST_HIZ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        temp_sensor_hiz != temp_sensor_enable)
        else $error("sensor enable and high impedance disagree");

    AST_HIZ_FOLLOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'h1 |=> temp_sensor_hiz == !$past(temp_sensor_enable_reg))
        else $error("sensor high impedance does not follow control");

    AST_SENS_FOLLOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'h1 |=> temp_sensor_enable == $past(temp_sensor_enable_reg))
        else $error("sensor enable does not follow control");

    AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_wr && sfr_addr == arsc_pkg::REF_CTRL_ADDR
        |=> analog_ground_select_reg == $past(sfr_wdata[arsc_pkg::FLD_GND_SEL])
        && reference_select_reg
           == $past(sfr_wdata[arsc_pkg::FLD_REFSEL_HI:arsc_pkg::FLD_REFSEL_LO])
        && temp_sensor_enable_reg == $past(sfr_wdata[arsc_pkg::FLD_TEMP_EN])
        && precision_ref_enable_reg == $past(sfr_wdata[arsc_pkg::FLD_PREC_EN]))
        else $error("control write not stored");

    AST_CTRL_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(sfr_wr && sfr_addr == arsc_pkg::REF_CTRL_ADDR) |=> $stable(reference_control_reg))
        else $error("control changed without a control write");

    AST_CTRL_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == arsc_pkg::REF_CTRL_ADDR
        |=> sfr_rdata == $past(reference_control_reg))
        else $error("control read data wrong");

    AST_CTRL_RSVD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == arsc_pkg::REF_CTRL_ADDR
        |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[1])
        else $error("control reserved bits not zero");

    AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_rd && sfr_addr != arsc_pkg::REF_CTRL_ADDR
        && sfr_addr != arsc_pkg::FACTORY_TEMP_OFFSET_LOW_ADDR && sfr_addr != arsc_pkg::FACTORY_TEMP_OFFSET_HIGH_ADDR
        |=> sfr_rdata == 8'h00)
        else $error("unmapped address read not zero");

    AST_FACTORY_TEMP_OFFSET_LOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == arsc_pkg::FACTORY_TEMP_OFFSET_LOW_ADDR
        |=> sfr_rdata[5:0] == 6'h00 && sfr_rdata[7:6] == FACTORY_TEMP_OFFSET[1:0])
        else $error("offset low byte wrong");

    AST_FACTORY_TEMP_OFFSET_HIGH: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == arsc_pkg::FACTORY_TEMP_OFFSET_HIGH_ADDR
        |=> sfr_rdata == FACTORY_TEMP_OFFSET[9:2])
        else $error("offset high byte wrong");

    AST_FACTORY_TEMP_OFFSET_CONST: assert property (@(posedge sys_clk) disable iff (!arst_n)
        factory_temp_offset_high == FACTORY_TEMP_OFFSET[9:2]
        && factory_temp_offset_low == {FACTORY_TEMP_OFFSET[1:0], 6'h00})
        else $error("offset views differ from the factory constant");
endmodule

// >>> dv/arsc_conv_model.sv
// Behavioural converter core: one tracking then converting pass per start
`timescale 1ns/1ps
module arsc_conv_model #(
    parameter int TRACK_CYC = 12,
    parameter int CONV_CYC  = 12
) (
    // Clock and command
    input  wire logic       sys_clk,
    input  wire logic       start,
    input  wire logic [4:0] chan_req,
    // Converter status
    output logic            conv_tracking,
    output logic            conv_converting,
    output logic [4:0]      conv_channel
);
    int cnt = 0;
    // Starts ignored while a pass is running
    always @(posedge sys_clk) begin
        if (start && cnt == 0)
            cnt <= TRACK_CYC + CONV_CYC;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign conv_tracking   = cnt > CONV_CYC;
    assign conv_converting = cnt > 0 && cnt <= CONV_CYC;
    assign conv_channel    = chan_req;
endmodule

// >>> dv/arsc_ref_ctrl_bench.sv
// Self-checking bench for the reference select control
`timescale 1ns/1ps
module arsc_ref_ctrl_bench;
    localparam logic [9:0] OFFSET = 10'h2B5;
    logic       sys_clk   = 1'b0;
    logic       arst_n    = 1'b0;
    logic [7:0] sfr_addr  = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic       sfr_rd    = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [4:0] chan_req  = 5'h00;
    logic       start     = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] rv;
    logic [4:0] conv_channel;
    logic [1:0] vref_mux_sel;
    logic       conv_tracking, conv_converting, hs_ref_enable, prec_ref_enable;
    logic       vref_pin_drive, gnd_use_analog_ground_pin_pin, gnd_use_internal;
    logic       temp_sensor_enable, temp_sensor_hiz;
    int         failures   = 0;
    int         num_checks = 0;

    always #10 sys_clk = ~sys_clk;

    arsc_conv_model CONV (.sys_clk, .start, .chan_req, .conv_tracking, .conv_converting,
                          .conv_channel);
    arsc_ref_ctrl #(.FACTORY_TEMP_OFFSET(OFFSET)) DUT (.sys_clk, .arst_n, .sfr_addr,
        .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv_tracking, .conv_converting,
        .conv_channel, .vref_mux_sel, .hs_ref_enable, .prec_ref_enable, .vref_pin_drive,
        .gnd_use_analog_ground_pin_pin, .gnd_use_internal, .temp_sensor_enable, .temp_sensor_hiz);

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        @(negedge sys_clk);
        rv = sfr_rdata;
    endtask

    task automatic t_reset;
        rd(8'hD1);
        chk("ctrl reset", rv, 8'h18);
        chk("mux reset", 8'(vref_mux_sel), 8'h03);
        chk("hiz reset", 8'(temp_sensor_hiz), 8'h01);
    endtask

    task automatic t_offset;
        wr(8'h86, 8'hFF);
        wr(8'h85, 8'hFF);
        rd(8'h86);
        chk("off high", rv, OFFSET[9:2]);
        rd(8'h85);
        chk("off low", rv, {OFFSET[1:0], 6'h00});
        rd(8'h40);
        chk("unmapped", rv, 8'h00);
    endtask

    task automatic t_bits;
        wr(8'hD1, 8'hFF);
        rd(8'hD1);
        chk("ctrl ff", rv, 8'h3D);
        chk("sens on", 8'({temp_sensor_enable, temp_sensor_hiz}), 8'h02);
        chk("analog_ground_pin on", 8'(gnd_use_analog_ground_pin_pin), 8'h01);
        wr(8'hD1, 8'h00);
        chk("sens off", 8'({temp_sensor_enable, temp_sensor_hiz}), 8'h01);
        chk("analog_ground_pin off", 8'(gnd_use_analog_ground_pin_pin), 8'h00);
        chk("ext ref", 8'({prec_ref_enable, vref_pin_drive}), 8'h00);
    endtask

    task automatic t_refsel;
        for (int s = 0; s < 4; s++) begin
            wr(8'hD1, {3'h0, 2'(s), 3'h1});
            chk("mux sel", 8'(vref_mux_sel), 8'(s));
            chk("prec", 8'({prec_ref_enable, vref_pin_drive}), (s == 0) ? 8'h03 : 8'h00);
        end
    endtask

    task automatic t_conv(input logic [4:0] ch, input logic [1:0] sel, input logic g);
        wr(8'hD1, {2'h0, g, sel, 3'h4});
        chan_req = ch;
        start    = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (9) @(negedge sys_clk);
        chk("hs track", 8'(hs_ref_enable), 8'(sel == 2'h3));
        chk("gnd track", 8'({gnd_use_internal, gnd_use_analog_ground_pin_pin}),
            (ch == 5'h1B) ? 8'h02 : 8'(g));
        repeat (12) @(negedge sys_clk);
        chk("hs conv", 8'(hs_ref_enable), 8'(sel == 2'h3));
        chk("gnd conv", 8'({gnd_use_internal, gnd_use_analog_ground_pin_pin}),
            (sel == 2'h3) ? 8'h02 : 8'(g));
        repeat (13) @(negedge sys_clk);
        chk("hs idle", 8'(hs_ref_enable), 8'h00);
        chk("gnd idle", 8'({gnd_use_internal, gnd_use_analog_ground_pin_pin}), 8'(g));
    endtask

    task automatic t_reset_mid;
        wr(8'hD1, 8'h25);
        chk("pre reset", 8'({prec_ref_enable, temp_sensor_hiz}), 8'h02);
        arst_n = 1'b0;
        #1;
        chk("async reset", 8'({vref_mux_sel, prec_ref_enable, temp_sensor_hiz}),
            8'h0D);
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        rd(8'hD1);
        chk("ctrl re-reset", rv, 8'h18);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_offset();
        t_bits();
        t_refsel();
        t_reset_mid();
        t_conv(5'h1B, 2'h1, 1'b1);
        t_conv(5'h03, 2'h3, 1'b1);
        t_conv(5'h1B, 2'h3, 1'b0);
        end_sim();
    end

    // Run needs well under 500 cycles
    initial begin
        #100us;
        failures++;
        end_sim();
    end
endmodule
